// ---- rtl/pin_ovr_cfg.svh ----
// Register map, field positions, reset values and timing for the pin override
`ifndef PIN_OVR_CFG_SVH
`define PIN_OVR_CFG_SVH

`define ADR_PORT_CTRL 8'h00
`define ADR_TW_CTRL 8'h04
`define ADR_PORTC 8'h08
`define ADR_PORTD 8'h0C
`define ADR_STATUS 8'h10

`define CTL_XMEM 0
`define CTL_XMM_LO 1
`define CTL_XMM_HI 3
`define CTL_PUD 4
`define CTL_TXON 5
`define CTL_RXON 6
`define CTL_SYNC 7
`define CTL_DIN 8
`define CTL_IRQ_LO 12
`define CTL_IRQ_HI 15
`define CTL_W 16
`define CTL_RST 16'h0100

`define TW_ON 0
`define TW_W 8
`define TW_RST 8'h00

`define PRT_OUT_LO 0
`define PRT_OUT_HI 7
`define PRT_DIR_LO 8
`define PRT_DIR_HI 15
`define PRT_W 16
`define PRT_RST 16'h0000

// Mask limit per Port C pin, pin 7 in the top three bits
`define XM_THR 24'h29CBBF

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define SPIKE_NS 50
`define CLK_NS 10
`define TW_IDLE 1'h1

`endif

// ---- rtl/pin_ovr_pkg.sv ----
// Shared types for the port C/D override block
package pin_ovr_pkg;
  typedef logic [7:0] pin_vec_t;
  typedef logic [31:0] word_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } bus_state_e;
endpackage

// ---- rtl/glitch_if.sv ----
// Raw and filtered two-wire pad lines between the top and the spike filter
`timescale 1ns/1ns
`default_nettype none
interface glitch_if #(parameter int N = 2);
  logic enable;
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport filt (input enable, input raw, output clean);
  modport user (output enable, output raw, input clean);
endinterface
`default_nettype wire

// ---- rtl/spike_filter.sv ----
// Per-line spike filter for the two-wire data and clock inputs
`timescale 1ns/1ns
`default_nettype none
`include "pin_ovr_cfg.svh"
module spike_filter #(
  parameter int N = 2,
  parameter int CYC = 5
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  glitch_if.filt fp // Raw lines in, filtered lines out
);
  localparam int CW = $clog2(CYC + 1);
  wire [N-1:0] clean_w;

  genvar ch;
  generate
    for (ch = 0; ch < N; ch++) begin : g_ch
      logic [CW-1:0] cnt_r;
      logic clean_r;
      wire same = (fp.raw[ch] == clean_r);
      wire done = (cnt_r == CW'(CYC - 1));
      // A change passes only after CYC cycles of the same level
      always_ff @(posedge clock) begin
        if (rst) begin
          cnt_r <= '0;
          clean_r <= `TW_IDLE;
        end else if (!fp.enable || same) begin
          cnt_r <= '0;
          clean_r <= fp.raw[ch];
        end else if (done) begin
          cnt_r <= '0;
          clean_r <= fp.raw[ch];
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
      assign clean_w[ch] = clean_r;
    end
  endgenerate

  assign fp.clean = clean_w;
endmodule
`default_nettype wire

// ---- rtl/port_cd_override.sv ----
// Port C/D alternate-function override with an AXI4-Lite register slave
// Functional notes
// - Port C pin n drives external address bit n+8 when memory takes it.
// - Pins C7..C4 overridden when memory on and mask below 1..4.
// - Pins C3..C0 overridden when memory on and mask below 5,6,7,7.
// - D5 drives sync clock when its direction bit set, else receives.
// - D5 clock function works only in synchronous USART mode.
// - D7..D4 feed timer clocks, sync clock, capture; only D5 overrides.
// - D4 pad input goes to the timer1 capture trigger.
// - Transmitter on forces D3 output with TX data, pull-up off.
// - Receiver on forces D2 input; pull-up from port bit, gated.
// - Two-wire on makes D1 open-drain SDA, value 0, dir from pull-low.
// - Two-wire on makes D0 open-drain SCL, value 0, dir from pull-low.
// - Two-wire inputs drop pulses shorter than 50 ns.
// - Interrupt enables force input enable on D3..D0.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pin_ovr_cfg.svh"
module port_cd_override
  import pin_ovr_pkg::*;
#(
  parameter int CLK_PERIOD_NS = `CLK_NS,
  parameter int SPIKE_WIDTH_NS = `SPIKE_NS
) (
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [7:0] awaddr, // Write byte address
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  output logic [1:0] bresp, // Write response code
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input wire logic [7:0] araddr, // Read byte address
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response code
  input wire logic [7:0] ext_addr_high, // External address bits 15..8
  input wire logic uart1_tx_line, // USART1 transmit data
  input wire logic uart1_clk_out, // USART1 sync clock to drive
  input wire logic sda_pull_low, // Two-wire logic pulls SDA low
  input wire logic scl_pull_low, // Two-wire logic pulls SCL low
  input wire logic [7:0] portc_pad_in, // Port C pad levels
  output logic [7:0] portc_pad_out, // Port C pad drive value
  output logic [7:0] portc_pad_oe_n, // Port C drive enable, low drives
  output logic [7:0] portc_pullup, // Port C pull-up on
  input wire logic [7:0] portd_pad_in, // Port D pad levels
  output logic [7:0] portd_pad_out, // Port D pad drive value
  output logic [7:0] portd_pad_oe_n, // Port D drive enable, low drives
  output logic [7:0] portd_pullup, // Port D pull-up on
  output logic timer0_ext_clock_in, // Timer0 counter source
  output logic timer1_ext_clock_in, // Timer1 counter source
  output logic uart1_sync_clock, // USART1 sync clock received
  output logic timer1_capture_in, // Timer1 capture trigger
  output logic uart1_rx_line, // USART1 receive data
  output logic [3:0] ext_irq_in, // External interrupt inputs 3..0
  output logic sda_in, // Filtered two-wire data
  output logic scl_in // Filtered two-wire clock
);
  localparam int SPIKE_CYC =
    (SPIKE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] XM_THR = `XM_THR;
  localparam int PINS = 16;

  // Registers
  logic [`CTL_W-1:0] ctrl_r;
  logic [`TW_W-1:0] tw_ctrl_r;
  logic [`PRT_W-1:0] portc_r;
  logic [`PRT_W-1:0] portd_r;

  // Write channel state
  bus_state_e wr_state_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  word_t w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // Read channel state
  logic arready_r;
  logic rvalid_r;
  word_t rdata_r;
  logic [1:0] rresp_r;

  // Registered pad and peripheral outputs
  pin_vec_t pc_out_r;
  pin_vec_t pc_oe_n_r;
  pin_vec_t pc_pu_r;
  pin_vec_t pd_out_r;
  pin_vec_t pd_oe_n_r;
  pin_vec_t pd_pu_r;
  logic t0_r;
  logic t1_r;
  logic xck_r;
  logic icp_r;
  logic rxd_r;
  logic [3:0] irq_r;
  logic sda_r;
  logic scl_r;

  // Control fields
  wire ext_memory_on = ctrl_r[`CTL_XMEM];
  wire [2:0] ext_addr_high_mask = ctrl_r[`CTL_XMM_HI:`CTL_XMM_LO];
  wire global_pullup_disable = ctrl_r[`CTL_PUD];
  wire uart1_tx_on = ctrl_r[`CTL_TXON];
  wire uart1_rx_on = ctrl_r[`CTL_RXON];
  wire uart1_sync_mode = ctrl_r[`CTL_SYNC];
  wire inputs_on = ctrl_r[`CTL_DIN];
  wire [3:0] irq_en = ctrl_r[`CTL_IRQ_HI:`CTL_IRQ_LO];
  wire two_wire_on = tw_ctrl_r[`TW_ON];
  wire pin_vec_t portd_out = portd_r[`PRT_OUT_HI:`PRT_OUT_LO];
  wire portd_dir_bit5 = portd_r[`PRT_DIR_LO + 5];

  // Bus handshakes
  wire aw_take = awvalid & awready_r;
  wire w_take = wvalid & wready_r;
  wire ar_take = arvalid & arready_r;
  wire wr_commit = (wr_state_r == BUS_IDLE) & aw_held_r & w_held_r;
  wire wr_done = bvalid_r & bready;
  wire aw_held_nxt = (aw_held_r | aw_take) & ~wr_commit;
  wire w_held_nxt = (w_held_r | w_take) & ~wr_commit;
  wire wr_idle_nxt = wr_commit ? 1'b0 :
                     (wr_state_r == BUS_IDLE) | wr_done;
  wire rvalid_nxt = rvalid_r ? ~rready : ar_take;

  // Byte-lane mask from the held strobes
  word_t wmask;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{w_strb_r[b]}};
    end
  endgenerate

  function automatic word_t merge(word_t old, word_t data, word_t mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  wire sel_ctrl = (aw_addr_r == `ADR_PORT_CTRL);
  wire sel_tw = (aw_addr_r == `ADR_TW_CTRL);
  wire sel_pc = (aw_addr_r == `ADR_PORTC);
  wire sel_pd = (aw_addr_r == `ADR_PORTD);
  wire wr_hit = sel_ctrl | sel_tw | sel_pc | sel_pd;
  wire word_t ctrl_m = merge(32'(ctrl_r), w_data_r, wmask);
  wire word_t tw_m = merge(32'(tw_ctrl_r), w_data_r, wmask);
  wire word_t pc_m = merge(32'(portc_r), w_data_r, wmask);
  wire word_t pd_m = merge(32'(portd_r), w_data_r, wmask);

  // Override vectors: Port C in bits 7..0, Port D in bits 15..8
  logic [PINS-1:0] pullup_override_en;
  logic [PINS-1:0] pullup_override_val;
  logic [PINS-1:0] dir_override_en;
  logic [PINS-1:0] dir_override_val;
  logic [PINS-1:0] pinval_override_en;
  logic [PINS-1:0] pinval_override_val;
  logic [PINS-1:0] input_enable_override_en;
  logic [PINS-1:0] input_enable_override_val;
  logic [PINS-1:0] pu_eff;
  logic [PINS-1:0] dir_eff;
  logic [PINS-1:0] val_eff;
  logic [PINS-1:0] ie_eff;
  pin_vec_t pc_take;

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_portc
      // Address pin belongs to memory while the mask leaves it free
      assign pc_take[n] = ext_memory_on &
                          (ext_addr_high_mask < XM_THR[3*n +: 3]);
      assign pullup_override_en[n] = pc_take[n];
      assign pullup_override_val[n] = 1'h0;
      assign dir_override_en[n] = pc_take[n];
      assign dir_override_val[n] = 1'h1;
      assign pinval_override_en[n] = pc_take[n];
      assign pinval_override_val[n] = ext_addr_high[n];
      assign input_enable_override_en[n] = 1'h0;
      assign input_enable_override_val[n] = 1'h0;
    end
  endgenerate

  // Clock is driven only in sync mode with the pin set as output
  wire xck_oe = uart1_sync_mode & portd_dir_bit5;
  wire pd_pu2 = portd_out[2] & ~global_pullup_disable;
  wire pd_pu1 = portd_out[1] & ~global_pullup_disable;
  wire pd_pu0 = portd_out[0] & ~global_pullup_disable;

  assign pullup_override_en[15:8] = {4'h0, uart1_tx_on, uart1_rx_on,
                       two_wire_on, two_wire_on};
  assign pullup_override_val[15:8] = {5'h00, pd_pu2, pd_pu1, pd_pu0};
  assign dir_override_en[15:8] = {2'h0, xck_oe, 1'h0, uart1_tx_on, uart1_rx_on,
                       two_wire_on, two_wire_on};
  // Open drain: direction follows the pull-low request, value stays 0
  assign dir_override_val[15:8] = {2'h0, 1'h1, 1'h0, 1'h1, 1'h0,
                       sda_pull_low, scl_pull_low};
  assign pinval_override_en[15:8] = {2'h0, xck_oe, 1'h0, uart1_tx_on, 1'h0,
                       two_wire_on, two_wire_on};
  assign pinval_override_val[15:8] = {2'h0, uart1_clk_out, 1'h0, uart1_tx_line,
                       3'h0};
  assign input_enable_override_en[15:8] = {4'h0, irq_en};
  assign input_enable_override_val[15:8] = {4'h0, 4'hF};

  wire [PINS-1:0] pin_out = {portd_r[`PRT_OUT_HI:`PRT_OUT_LO],
                             portc_r[`PRT_OUT_HI:`PRT_OUT_LO]};
  wire [PINS-1:0] pin_dir = {portd_r[`PRT_DIR_HI:`PRT_DIR_LO],
                             portc_r[`PRT_DIR_HI:`PRT_DIR_LO]};

  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_pin
      wire norm_pu = pin_out[p] & ~pin_dir[p] & ~global_pullup_disable;
      assign pu_eff[p] = pullup_override_en[p] ? pullup_override_val[p] : norm_pu;
      assign dir_eff[p] = dir_override_en[p] ? dir_override_val[p] : pin_dir[p];
      assign val_eff[p] = pinval_override_en[p] ? pinval_override_val[p] : pin_out[p];
      assign ie_eff[p] = input_enable_override_en[p] ? input_enable_override_val[p] : inputs_on;
    end
  endgenerate

  // Digital input path after the input-enable gate
  wire [PINS-1:0] pin_in = {portd_pad_in, portc_pad_in} & ie_eff;
  wire pin_vec_t pc_in = pin_in[7:0];
  wire pin_vec_t pd_in = pin_in[15:8];

  // Two-wire lines take the pad before the digital gate
  glitch_if #(.N(2)) tw_if ();
  assign tw_if.enable = two_wire_on;
  assign tw_if.raw = portd_pad_in[1:0];

  spike_filter #(
    .N(2),
    .CYC(SPIKE_CYC)
  ) u_spike (
    .clock(clock),
    .rst(rst),
    .fp(tw_if.filt)
  );

  // Read decode
  wire word_t status_w = {dir_eff[7:0], dir_eff[15:8], pd_in, pc_in};
  wire rd_ctrl = (araddr == `ADR_PORT_CTRL);
  wire rd_tw = (araddr == `ADR_TW_CTRL);
  wire rd_pc = (araddr == `ADR_PORTC);
  wire rd_pd = (araddr == `ADR_PORTD);
  wire rd_st = (araddr == `ADR_STATUS);
  wire rd_hit = rd_ctrl | rd_tw | rd_pc | rd_pd | rd_st;
  wire word_t rd_word = rd_ctrl ? 32'(ctrl_r) :
                        rd_tw ? 32'(tw_ctrl_r) :
                        rd_pc ? 32'(portc_r) :
                        rd_pd ? 32'(portd_r) :
                        rd_st ? status_w : '0;

  // Write channel
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state_r <= BUS_IDLE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= wr_idle_nxt & ~aw_held_nxt;
      wready_r <= wr_idle_nxt & ~w_held_nxt;
      if (wr_commit) begin
        wr_state_r <= BUS_RESP;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (wr_done) begin
        wr_state_r <= BUS_IDLE;
        bvalid_r <= 1'b0;
      end
    end
  end

  // Held payloads need no reset
  always_ff @(posedge clock) begin
    if (aw_take) aw_addr_r <= {awaddr[7:2], 2'h0};
    if (w_take) begin
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
  end

  // Register file
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `CTL_RST;
      tw_ctrl_r <= `TW_RST;
      portc_r <= `PRT_RST;
      portd_r <= `PRT_RST;
    end else if (wr_commit) begin
      if (sel_ctrl) ctrl_r <= ctrl_m[`CTL_W-1:0];
      if (sel_tw) tw_ctrl_r <= tw_m[`TW_W-1:0];
      if (sel_pc) portc_r <= pc_m[`PRT_W-1:0];
      if (sel_pd) portd_r <= pd_m[`PRT_W-1:0];
    end
  end

  // Read channel: answer on the same edge that takes the address
  always_ff @(posedge clock) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // Pads and peripheral inputs, registered so every output is a flop
  always_ff @(posedge clock) begin
    if (rst) begin
      pc_out_r <= '0;
      pc_oe_n_r <= '1;
      pc_pu_r <= '0;
      pd_out_r <= '0;
      pd_oe_n_r <= '1;
      pd_pu_r <= '0;
    end else begin
      pc_out_r <= val_eff[7:0];
      pc_oe_n_r <= ~dir_eff[7:0];
      pc_pu_r <= pu_eff[7:0];
      pd_out_r <= val_eff[15:8];
      pd_oe_n_r <= ~dir_eff[15:8];
      pd_pu_r <= pu_eff[15:8];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      t0_r <= 1'b0;
      t1_r <= 1'b0;
      xck_r <= 1'b0;
      icp_r <= 1'b0;
      rxd_r <= 1'b0;
      irq_r <= '0;
      sda_r <= `TW_IDLE;
      scl_r <= `TW_IDLE;
    end else begin
      t0_r <= pd_in[7];
      t1_r <= pd_in[6];
      xck_r <= uart1_sync_mode & pd_in[5];
      icp_r <= pd_in[4];
      rxd_r <= pd_in[2];
      irq_r <= pd_in[3:0];
      sda_r <= tw_if.clean[1];
      scl_r <= tw_if.clean[0];
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign portc_pad_out = pc_out_r;
  assign portc_pad_oe_n = pc_oe_n_r;
  assign portc_pullup = pc_pu_r;
  assign portd_pad_out = pd_out_r;
  assign portd_pad_oe_n = pd_oe_n_r;
  assign portd_pullup = pd_pu_r;
  assign timer0_ext_clock_in = t0_r;
  assign timer1_ext_clock_in = t1_r;
  assign uart1_sync_clock = xck_r;
  assign timer1_capture_in = icp_r;
  assign uart1_rx_line = rxd_r;
  assign ext_irq_in = irq_r;
  assign sda_in = sda_r;
  assign scl_in = scl_r;
endmodule
`default_nettype wire

// ---- tb/pin_ovr_assertions.sv ----
// Port-level checker for the port C/D override block
`timescale 1ns/1ns
`default_nettype none
module pin_ovr_assertions (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  input wire logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [1:0] bresp, // Write response code
  input wire logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [31:0] rdata, // Read data
  input wire logic [7:0] portc_pad_oe_n, // Port C drive enable
  input wire logic [7:0] portc_pullup, // Port C pull-up
  input wire logic [7:0] portd_pad_in, // Port D pad levels
  input wire logic [7:0] portd_pad_oe_n, // Port D drive enable
  input wire logic [7:0] portd_pullup, // Port D pull-up
  input wire logic timer1_capture_in, // Capture trigger
  input wire logic uart1_sync_clock, // Sync clock received
  input wire logic uart1_rx_line, // Receive data
  input wire logic [3:0] ext_irq_in, // Interrupt inputs
  input wire logic sda_in // Filtered data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_b_late;
    !bvalid ##1 bvalid;
  endsequence
  a_wr_latency: assert property (s_wr_take |=> s_b_late)
    else $error("write response not two edges after take");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rd_latency: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data not one edge after take");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_aw_return: assert property (bvalid && bready |=> awready && wready)
    else $error("write channels not ready after response");
  a_rx_pad: assert property (uart1_rx_line |-> $past(portd_pad_in[2]))
    else $error("receive line high without pad high");
  a_capture_pad: assert property (
    timer1_capture_in |-> $past(portd_pad_in[4]))
    else $error("capture input high without pad high");
  a_sync_pad: assert property (
    uart1_sync_clock |-> $past(portd_pad_in[5]))
    else $error("sync clock high without pad high");
  a_irq_pad: assert property (
    (ext_irq_in & ~$past(portd_pad_in[3:0])) == 4'h0)
    else $error("interrupt input high without pad high");
  a_sda_follow: assert property (
    $changed(sda_in) |-> sda_in == $past(portd_pad_in[1], 2))
    else $error("filtered data moved against its pad");
  a_pull_drive: assert property (
    (portc_pullup & ~portc_pad_oe_n) == 8'h00 &&
    (portd_pullup[7:2] & ~portd_pad_oe_n[7:2]) == 6'h00)
    else $error("pull-up on while pin driven");
endmodule
bind port_cd_override pin_ovr_assertions chk_i (.clock(clock), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .portc_pad_oe_n(portc_pad_oe_n), .portc_pullup(portc_pullup),
  .portd_pad_in(portd_pad_in), .portd_pad_oe_n(portd_pad_oe_n),
  .portd_pullup(portd_pullup), .timer1_capture_in(timer1_capture_in),
  .uart1_sync_clock(uart1_sync_clock), .uart1_rx_line(uart1_rx_line),
  .ext_irq_in(ext_irq_in), .sda_in(sda_in));
`default_nettype wire

// ---- tb/pad_board.sv ----
// Board model of one 8-pin port: block drive, board drive, pull-ups
`timescale 1ns/1ns
`default_nettype none
module pad_board (
  input wire logic clock, // System clock
  input wire logic [7:0] oe_n, // Block drive enable, low drives
  input wire logic [7:0] drv, // Block drive value
  input wire logic [7:0] pu, // Block pull-up on
  input wire logic [7:0] ext_en, // Board driver on
  input wire logic [7:0] ext_val, // Board driver value
  output logic [7:0] level // Pad level seen by the block
);
  logic flt_r;
  initial flt_r = 1'b0;
  // Undriven lines toggle so a stale level never passes for a real one
  always @(posedge clock) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i])
        level[i] = drv[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (pu[i])
        level[i] = 1'b1;
      else
        level[i] = flt_r;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the port C/D override block
`timescale 1ns/1ns
`default_nettype none
`include "pin_ovr_cfg.svh"
module testbench;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, uart1_tx_line, uart1_clk_out;
  logic sda_pull_low, scl_pull_low, timer0_ext_clock_in, timer1_ext_clock_in;
  logic uart1_sync_clock, timer1_capture_in, uart1_rx_line, sda_in, scl_in;
  logic [7:0] awaddr, araddr, ext_addr_high, pc_in, pc_out, pc_oe_n, pc_pu;
  logic [7:0] pd_in, pd_out, pd_oe_n, pd_pu, dext_en, dext_val;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, ext_irq_in;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int num_checks = 0;
  port_cd_override dut (.clock(clock), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ext_addr_high(ext_addr_high), .uart1_tx_line(uart1_tx_line),
    .uart1_clk_out(uart1_clk_out), .sda_pull_low(sda_pull_low),
    .scl_pull_low(scl_pull_low), .portc_pad_in(pc_in),
    .portc_pad_out(pc_out), .portc_pad_oe_n(pc_oe_n), .portc_pullup(pc_pu),
    .portd_pad_in(pd_in), .portd_pad_out(pd_out), .portd_pad_oe_n(pd_oe_n),
    .portd_pullup(pd_pu), .timer0_ext_clock_in(timer0_ext_clock_in),
    .timer1_ext_clock_in(timer1_ext_clock_in),
    .uart1_sync_clock(uart1_sync_clock),
    .timer1_capture_in(timer1_capture_in), .uart1_rx_line(uart1_rx_line),
    .ext_irq_in(ext_irq_in), .sda_in(sda_in), .scl_in(scl_in));
  pad_board brd_c (.clock(clock), .oe_n(pc_oe_n), .drv(pc_out), .pu(pc_pu),
    .ext_en(8'h00), .ext_val(8'h00), .level(pc_in));
  pad_board brd_d (.clock(clock), .oe_n(pd_oe_n), .drv(pd_out), .pu(pd_pu),
    .ext_en(dext_en), .ext_val(dext_val), .level(pd_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    num_errors++;
    $display("[ERR] %0t bus wait ran out", $time);
    finish_test();
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (n >= 50) timeout();
    chk(bresp, r);
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (n >= 50) timeout();
    chk(rdata, e);
    chk(rresp, r);
    rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic t_regs();
    chk(pc_oe_n, 8'hFF);
    chk(sda_in, 1'b1);
    rd(`ADR_PORT_CTRL, 32'h0000_0100, `RESP_OKAY);
    rd(`ADR_TW_CTRL, 32'h0, `RESP_OKAY);
    rd(`ADR_PORTD, 32'h0, `RESP_OKAY);
    rd(8'h14, 32'h0, `RESP_SLVERR);
    wr(`ADR_STATUS, 32'hFFFF_FFFF, `RESP_SLVERR);
    wstrb <= 4'h2;
    wr(`ADR_PORTC, 32'hFFFF_FFFF, `RESP_OKAY);
    wstrb <= 4'hF;
    rd(`ADR_PORTC, 32'h0000_FF00, `RESP_OKAY);
  endtask
  task automatic t_portc();
    logic [7:0] ov;
    ext_addr_high <= 8'hA5;
    wr(`ADR_PORTC, 32'h0000_00FF, `RESP_OKAY);
    for (int m = 0; m < 9; m++) begin
      wr(`ADR_PORT_CTRL, 32'h0100 | ((m % 8) << 1) | (m < 8), `RESP_OKAY);
      cyc(2);
      // Pin 7 frees at mask 1, pins 1 and 0 share the limit of 7
      for (int n = 0; n < 8; n++) ov[n] = m < ((n > 0) ? 8 - n : 7);
      chk(pc_oe_n, 8'(~ov));
      chk(pc_out, 8'((ov & 8'hA5) | ~ov));
      chk(pc_pu, 8'(~ov));
    end
  endtask
  task automatic t_uart();
    logic [7:0] v;
    wr(`ADR_PORTD, 32'h0000_2404, `RESP_OKAY);
    wr(`ADR_PORT_CTRL, 32'h0000_01E0, `RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      uart1_tx_line <= i[0];
      uart1_clk_out <= !i[0];
      // Clock goes out, back through the pad, then into its input flop
      cyc(3);
      chk(pd_oe_n[5:2], 4'b0101);
      chk(pd_out[3], i[0]);
      chk(pd_out[5], !i[0]);
      chk(pd_pu[3:2], 2'b01);
      chk(uart1_sync_clock, !i[0]);
    end
    wr(`ADR_PORTD, 32'h0000_0404, `RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'hB4 : 8'h40;
      dext_val <= v;
      cyc(2);
      chk(pd_oe_n[5], 1'b1);
      chk({timer0_ext_clock_in, timer1_ext_clock_in, uart1_sync_clock,
           timer1_capture_in, uart1_rx_line},
          {v[7], v[6], v[5], v[4], v[2]});
    end
    wr(`ADR_PORT_CTRL, 32'h0000_0170, `RESP_OKAY);
    cyc(2);
    chk(pd_pu[2], 1'b0);
    chk(uart1_sync_clock, 1'b0);
  endtask
  task automatic spike(input int w, input logic e);
    logic low;
    low = 1'b0;
    dext_en[0] <= 1'b1;
    dext_val[0] <= 1'b0;
    cyc(w);
    dext_en[0] <= 1'b0;
    repeat (10) begin
      @(posedge clock);
      if (scl_in === 1'b0) low = 1'b1;
    end
    chk(low, e);
  endtask
  task automatic t_twi();
    wr(`ADR_PORTD, 32'h0000_0003, `RESP_OKAY);
    wr(`ADR_PORT_CTRL, 32'h0000_0100, `RESP_OKAY);
    wr(`ADR_TW_CTRL, 32'h0000_0001, `RESP_OKAY);
    sda_pull_low <= 1'b1;
    cyc(2);
    chk(pd_oe_n[1:0], 2'b01);
    chk(pd_out[1:0], 2'b00);
    chk(pd_pu[1:0], 2'b11);
    cyc(8);
    chk(sda_in, 1'b0);
    sda_pull_low <= 1'b0;
    cyc(8);
    chk(sda_in, 1'b1);
    spike(4, 1'b0);
    spike(5, 1'b1);
    scl_pull_low <= 1'b1;
    cyc(2);
    chk(pd_oe_n[1:0], 2'b10);
    scl_pull_low <= 1'b0;
    // Inputs off: only enabled interrupt pins and the two-wire filter still see their pads
    wr(`ADR_PORT_CTRL, 32'h0000_1000, `RESP_OKAY);
    cyc(2);
    chk(ext_irq_in, 4'b0001);
    chk(timer0_ext_clock_in, 1'b0);
    wr(`ADR_PORT_CTRL, 32'h0000_7000, `RESP_OKAY);
    dext_en[0] <= 1'b1;
    cyc(2);
    chk(ext_irq_in, 4'b0110);
  endtask
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {uart1_tx_line, uart1_clk_out, sda_pull_low, scl_pull_low} = 4'h0;
    {awaddr, araddr, ext_addr_high} = 24'h000000;
    wdata = 32'h0;
    wstrb = 4'hF;
    dext_en = 8'hF4;
    dext_val = 8'h00;
    cyc(8);
    rst <= 1'b0;
    cyc(2);
    t_regs();
    t_portc();
    t_uart();
    t_twi();
    finish_test();
  end
endmodule
`default_nettype wire
